/* pkg/pplb_pkg.sv */
// constants, register map and types of the packet bridge
package pplb_pkg;
    // ********************************************************
    // widths
    // ********************************************************
    localparam int DATA_W   = 32;
    localparam int BYTE_W   = 8;
    localparam int LANES    = DATA_W / BYTE_W;
    localparam int MOD_W    = 2;
    localparam int CH_W     = 3;
    localparam int PADDR_W  = 8;
    localparam int DEPTH    = 16;
    localparam int CNT_W    = 16;
    localparam int EVAL_W   = 40;
    localparam int SYNC_N   = 3;

    // ********************************************************
    // register offsets (byte addresses)
    // ********************************************************
    localparam logic [PADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [PADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [PADDR_W-1:0] REG_ERRCNT = 8'h08;
    localparam logic [PADDR_W-1:0] REG_PKTCNT = 8'h0C;

    // ********************************************************
    // field layout
    // ********************************************************
    localparam int CTRL_EN      = 0;
    localparam int CTRL_ERRMODE = 1;
    localparam int CTRL_ERRPIN  = 2;
    localparam int CTRL_ODD     = 3;
    localparam int CTRL_CH_LSB  = 4;
    localparam int CTRL_W       = CTRL_CH_LSB + CH_W;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h05;
    localparam int STAT_EMPTY   = 8;
    localparam int STAT_TIMEOUT = 9;
    localparam int STAT_BUSY    = 10;
    localparam int STAT_TETHER  = 11;

    // ********************************************************
    // evaluation limit
    // ********************************************************
    localparam longint EVAL_TIME_S = 3600;
    localparam longint CLK_HZ      = 250_000_000;
    localparam longint EVAL_CYCLES_DEF = EVAL_TIME_S * CLK_HZ;

    // ********************************************************
    // link state machine
    // ********************************************************
    typedef enum logic [2:0] {
        LK_IDLE = 3'b001,
        LK_DATA = 3'b010,
        LK_HALT = 3'b100
    } pplb_link_t;
endpackage

/* hw/pplb_bridge.sv */
// packet bridge: streaming sink port, packet fifo, 32 to 8 packet source
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
module pplb_bridge
    import pplb_pkg::*;
#(
    parameter int          FIFO_DEPTH  = DEPTH,
    parameter longint      EVAL_CYCLES = EVAL_CYCLES_DEF
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [PADDR_W-1:0]  paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [DATA_W-1:0]   pwdata,
    output logic      [DATA_W-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                s_valid,
    output logic                     s_ready,
    input  wire logic [DATA_W-1:0]   s_data,
    input  wire logic                s_sop,
    input  wire logic                s_eop,
    input  wire logic [MOD_W-1:0]    s_mod,
    input  wire logic                s_par,
    input  wire logic                tethered,
    input  wire logic                a_clk,
    input  wire logic                a_enb_n,
    output logic                     a_wr,
    output logic                     a_val,
    output logic                     primary_channel_marker_out,
    output logic                     a_sop,
    output logic                     a_eop,
    output logic                     a_err,
    output logic                     a_par,
    output logic      [BYTE_W-1:0]   a_data,
    output logic      [CH_W-1:0]     a_addr,
    output logic                     a_ppav,
    output logic                     timed_out
);
    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam int ENT_W = DATA_W + MOD_W + 3;
    localparam logic [PTR_W:0] DEPTH_V = (PTR_W+1)'(FIFO_DEPTH);
    localparam logic [EVAL_W-1:0] EVAL_LIM = EVAL_W'(EVAL_CYCLES);
    localparam logic [MOD_W-1:0] LAST_LANE = MOD_W'(LANES - 1);

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    // bit 0 link clock, bit 1 link enable, bit 2 tether strap
    logic [SYNC_N-1:0] sync1, sync2, sync3, filt;
    logic              a_clk_prev;
    logic              step;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 3'h2;
            sync2 <= 3'h2;
            sync3 <= 3'h2;
        end else begin
            sync1 <= {tethered, a_enb_n, a_clk};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // a level counts only once the second and third stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt       <= 3'h2;
            a_clk_prev <= 1'b0;
        end else begin
            filt       <= (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
            a_clk_prev <= filt[0];
        end
    end

    // outputs change on the falling link edge, stable for the far rising edge
    assign step = a_clk_prev & ~filt[0];

    // ********************************************************
    // apb registers
    // ********************************************************
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0]  err_cnt;
    logic [CNT_W-1:0]  pkt_cnt;
    logic              wr_en, rd_en, mapped;
    logic              in_err_inc, pkt_done;
    logic [PTR_W:0]    count;
    pplb_link_t        state;
    logic [DATA_W-1:0] rd_mux;

    // writes land only at the edge that completes the access
    assign wr_en  = psel & penable & pwrite & pready;
    assign rd_en  = psel & penable & ~pwrite & ~pready;
    assign mapped = (paddr == REG_CTRL) | (paddr == REG_STATUS) |
                    (paddr == REG_ERRCNT) | (paddr == REG_PKTCNT);

    always_comb begin
        rd_mux = '0;
        case (paddr)
            REG_CTRL:   rd_mux = DATA_W'(ctrl);
            REG_STATUS: begin
                rd_mux[PTR_W:0]      = count;
                rd_mux[STAT_EMPTY]   = (count == '0);
                rd_mux[STAT_TIMEOUT] = timed_out;
                rd_mux[STAT_BUSY]    = (state == LK_DATA);
                rd_mux[STAT_TETHER]  = filt[2];
            end
            REG_ERRCNT: rd_mux = DATA_W'(err_cnt);
            REG_PKTCNT: rd_mux = DATA_W'(pkt_cnt);
            default:    rd_mux = '0;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (rd_en) begin
                prdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_en && paddr == REG_CTRL) begin
            ctrl <= pwdata[CTRL_W-1:0];
        end
    end

    // counters clear on write; a count in the same cycle is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_cnt <= '0;
        end else if (wr_en && paddr == REG_ERRCNT) begin
            err_cnt <= CNT_W'(in_err_inc);
        end else begin
            err_cnt <= err_cnt + CNT_W'(in_err_inc);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_cnt <= '0;
        end else if (wr_en && paddr == REG_PKTCNT) begin
            pkt_cnt <= CNT_W'(pkt_done);
        end else begin
            pkt_cnt <= pkt_cnt + CNT_W'(pkt_done);
        end
    end

    // ********************************************************
    // evaluation timer
    // ********************************************************
    logic [EVAL_W-1:0] eval_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eval_cnt  <= '0;
            timed_out <= 1'b0;
        end else if (!filt[2] && !timed_out) begin
            eval_cnt <= eval_cnt + 1'b1;
            if (eval_cnt >= EVAL_LIM - 1'b1) begin
                timed_out <= 1'b1;
            end
        end
    end

    // ********************************************************
    // sink port and parity check
    // ********************************************************
    logic              push, pop;
    logic              par_calc, par_bad;
    logic [PTR_W:0]    next_count;
    logic [PTR_W-1:0]  wr_ptr, rd_ptr;
    logic [ENT_W-1:0]  mem [FIFO_DEPTH];
    logic [ENT_W-1:0]  head;

    // only this direction exists: sink in, packet source out
    assign push = s_valid & s_ready;
    assign par_calc = ctrl[CTRL_ODD] ? ~^s_data : ^s_data;
    assign par_bad  = s_par != par_calc;
    assign in_err_inc = push & par_bad;
    assign next_count = count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

    // ready is registered from the next fill level, so it never lies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ready <= 1'b0;
        end else begin
            s_ready <= (next_count < DEPTH_V) & ctrl[CTRL_EN] & ~timed_out;
        end
    end

    // ********************************************************
    // packet fifo
    // ********************************************************
    // single clock domain here, so binary pointers are safe; a gray
    // crossing is only needed when the sink port has its own clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= wr_ptr + PTR_W'(push);
            rd_ptr <= rd_ptr + PTR_W'(pop);
            count  <= next_count;
        end
    end

    // entry holds the 32-bit word plus modulo, sop, eop and the parity-error flag
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= {par_bad, s_mod, s_eop, s_sop, s_data};
        end
    end

    assign head = mem[rd_ptr];

    // ********************************************************
    // width converter and packet source
    // ********************************************************
    logic [DATA_W-1:0] h_data;
    logic              h_sop, h_eop, h_err;
    logic [MOD_W-1:0]  h_mod, lane, last_lane;
    logic [BYTE_W-1:0] lane_byte;
    logic              emit, pkt_err, byte_par;

    assign {h_err, h_mod, h_eop, h_sop, h_data} = head;
    // modulo counts the unused trailing bytes of the last word
    assign last_lane = h_eop ? LAST_LANE - h_mod : LAST_LANE;
    assign lane_byte = h_data[DATA_W-1-BYTE_W*lane -: BYTE_W];
    assign emit = step & (state == LK_DATA) & ~filt[1] & (count != '0);
    assign pop  = emit & (lane == last_lane);
    assign pkt_done = pop & h_eop;
    assign byte_par = ctrl[CTRL_ODD] ? ~^lane_byte : ^lane_byte;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane <= '0;
        end else if (pop) begin
            lane <= '0;
        end else if (emit) begin
            lane <= lane + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= LK_IDLE;
        end else if (timed_out) begin
            state <= LK_HALT;
        end else if (step) begin
            case (state)
                LK_IDLE: begin
                    if (count != '0 && !filt[1]) begin
                        state <= LK_DATA;
                    end
                end
                LK_DATA: begin
                    if (pkt_done) begin
                        state <= LK_IDLE;
                    end
                end
                LK_HALT: state <= LK_HALT;
                default: state <= LK_IDLE;
            endcase
        end
    end

    // accumulated packet error, released at the packet end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_err <= 1'b0;
        end else if (pkt_done) begin
            pkt_err <= 1'b0;
        end else if (emit && h_err) begin
            pkt_err <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_wr   <= 1'b0;
            a_val  <= 1'b0;
            a_sop  <= 1'b0;
            a_eop  <= 1'b0;
            a_err  <= 1'b0;
            a_par  <= 1'b0;
            a_data <= '0;
            primary_channel_marker_out <= 1'b0;
        end else if (timed_out) begin
            a_wr   <= 1'b0;
            a_val  <= 1'b0;
            a_sop  <= 1'b0;
            a_eop  <= 1'b0;
            a_err  <= 1'b1;
            a_par  <= 1'b0;
            a_data <= '0;
            primary_channel_marker_out <= 1'b0;
        end else if (step) begin
            a_wr  <= emit;
            a_val <= emit;
            a_sop <= emit & h_sop & (lane == '0);
            a_eop <= pop & h_eop;
            // error pin is only meaningful on the end byte of a packet
            a_err <= ctrl[CTRL_ERRPIN] & pop & h_eop & (pkt_err | h_err);
            if (state == LK_IDLE && count != '0 && !filt[1]) begin
                // channel select: address goes out on the data lines
                primary_channel_marker_out <= 1'b1;
                a_data <= BYTE_W'(ctrl[CTRL_CH_LSB +: CH_W]);
                a_par  <= 1'b0;
            end else begin
                primary_channel_marker_out <= 1'b0;
                a_data <= emit ? lane_byte : '0;
                // every byte cut from a bad word carries the mark
                if (ctrl[CTRL_ERRMODE]) begin
                    a_par <= emit & h_err;
                end else begin
                    a_par <= emit & (byte_par ^ h_err);
                end
            end
        end
    end

    // ********************************************************
    // channel address and packet available
    // ********************************************************
    // one secondary port, so exactly one channel of the primary is fed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_addr <= '0;
            a_ppav <= 1'b0;
        end else if (timed_out) begin
            a_addr <= '0;
            a_ppav <= 1'b0;
        end else begin
            a_addr <= ctrl[CTRL_CH_LSB +: CH_W];
            a_ppav <= next_count != '0;
        end
    end
endmodule

/* verif/pplb_bridge_chk.sv */
// assertion checker for the packet bridge ports
`timescale 1ns/1ns
module pplb_bridge_chk
    import pplb_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              s_valid,
    input wire logic              s_ready,
    input wire logic              tethered,
    input wire logic              a_wr,
    input wire logic              a_val,
    input wire logic              primary_channel_marker_out,
    input wire logic              a_sop,
    input wire logic              a_eop,
    input wire logic              a_err,
    input wire logic              a_par,
    input wire logic [BYTE_W-1:0] a_data,
    input wire logic [CH_W-1:0]   a_addr,
    input wire logic              a_ppav,
    input wire logic              timed_out
);
    // ********************************************************
    // properties
    // ********************************************************
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rdy_one;
        pready |=> !pready;
    endproperty
    property p_rdy_cause;
        pready |-> $past(psel && penable) && psel && penable;
    endproperty
    property p_err_rdy;
        pslverr |-> pready;
    endproperty
    property p_ppav_push;
        $rose(a_ppav) |-> $past(s_valid && s_ready);
    endproperty
    // a byte stands a whole link period, far longer than 8 cycles
    property p_byte_hold;
        $rose(a_wr) |-> a_wr[*8];
    endproperty
    property p_flags_wr;
        (a_sop || a_eop) |-> a_wr && a_val;
    endproperty
    property p_mark_ch;
        primary_channel_marker_out |-> a_data[CH_W-1:0] == a_addr && !a_wr;
    endproperty
    property p_par_idle;
        !a_wr |-> !a_par;
    endproperty
    property p_err_eop;
        a_wr && a_err |-> a_eop;
    endproperty
    property p_tether;
        tethered [*5] |-> !$rose(timed_out);
    endproperty
    property p_expire;
        timed_out |=> !a_wr && !a_val && !primary_channel_marker_out
            && !a_sop && !a_eop && a_err && a_data == 8'h00 && !a_ppav
            && !s_ready && timed_out;
    endproperty

    a_rdy_one:   assert property (p_rdy_one) else $error("pready too long");
    a_rdy_cause: assert property (p_rdy_cause) else $error("stray pready");
    a_err_rdy:   assert property (p_err_rdy) else $error("lone pslverr");
    a_ppav_push: assert property (p_ppav_push)
        else $error("ppav rose without a push");
    a_byte_hold: assert property (p_byte_hold)
        else $error("link byte too short");
    a_flags_wr:  assert property (p_flags_wr)
        else $error("packet flag outside a byte");
    a_mark_ch:   assert property (p_mark_ch)
        else $error("marker channel wrong");
    a_par_idle:  assert property (p_par_idle)
        else $error("parity outside data");
    a_err_eop:   assert property (p_err_eop)
        else $error("error flag before packet end");
    a_tether:    assert property (p_tether)
        else $error("expired while tethered");
    a_expire:    assert property (p_expire)
        else $error("outputs not forced after expiry");

    c_err_eop: cover property (a_eop && a_err);
    c_expire:  cover property (timed_out);
    c_slverr:  cover property (pslverr);
    c_marker:  cover property (primary_channel_marker_out);
endmodule

bind pplb_bridge pplb_bridge_chk u_chk (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .s_valid, .s_ready, .tethered, .a_wr, .a_val,
    .primary_channel_marker_out, .a_sop, .a_eop, .a_err, .a_par, .a_data,
    .a_addr, .a_ppav, .timed_out);

/* verif/pplb_link_model.sv */
// far side of the link: clock source, pause control, byte collector
`timescale 1ns/1ns
module pplb_link_model
    import pplb_pkg::*;
(
    input  wire logic              run,
    input  wire logic              stall,
    input  wire logic              a_wr,
    input  wire logic              a_sop,
    input  wire logic              a_eop,
    input  wire logic              a_err,
    input  wire logic              a_par,
    input  wire logic              primary_channel_marker_out,
    input  wire logic [BYTE_W-1:0] a_data,
    output logic                   a_clk,
    output logic                   a_enb_n
);
    logic [11:0]     q[$];
    logic [CH_W-1:0] last_ch = '0;

    // ********************************************************
    // clock, still outside frames, odd phase to pclk
    // ********************************************************
    initial begin
        a_clk = 1'b0;
        #13;
        forever begin
            #40;
            a_clk = run ? ~a_clk : 1'b0;
        end
    end
    assign a_enb_n = stall;

    // ********************************************************
    // capture on rising edge, mid-way through each byte
    // ********************************************************
    always @(posedge a_clk) begin
        if (primary_channel_marker_out)
            last_ch <= a_data[CH_W-1:0];
        if (a_wr)
            q.push_back({a_sop, a_eop, a_err, a_par, a_data});
    end
endmodule

/* verif/test_pplb_bridge.sv */
// self-checking bench for the packet bridge
`timescale 1ns/1ns
module test_pplb_bridge
    import pplb_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic s_valid, s_ready, s_sop, s_eop, s_par, tethered, run, stall;
    logic a_clk, a_enb_n, a_wr, a_val, a_sop, a_eop, a_err, a_par;
    logic primary_channel_marker_out, a_ppav, timed_out, rerr, odd;
    logic [PADDR_W-1:0] paddr;
    logic [DATA_W-1:0]  pwdata, prdata, s_data, rdata;
    logic [MOD_W-1:0]   s_mod;
    logic [BYTE_W-1:0]  a_data;
    logic [CH_W-1:0]    a_addr;
    logic [11:0]        exp_q[$];
    int                 err_count, n_checks;

    pplb_bridge #(.FIFO_DEPTH(16), .EVAL_CYCLES(3000)) dut (.pclk, .presetn,
        .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .s_valid, .s_ready, .s_data, .s_sop, .s_eop, .s_mod,
        .s_par, .tethered, .a_clk, .a_enb_n, .a_wr, .a_val,
        .primary_channel_marker_out, .a_sop, .a_eop, .a_err, .a_par,
        .a_data, .a_addr, .a_ppav, .timed_out);
    pplb_link_model u_link (.run, .stall, .a_wr, .a_sop, .a_eop, .a_err,
        .a_par, .primary_channel_marker_out, .a_data, .a_clk, .a_enb_n);

    // ********************************************************
    // tasks
    // ********************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [PADDR_W-1:0] ad,
                       input logic [DATA_W-1:0] wd);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic sw(input logic [31:0] d, input logic sop, eop,
                      input logic [1:0] md, input logic bad);
        @(posedge pclk);
        s_valid <= 1'b1;
        s_data  <= d;
        s_sop   <= sop;
        s_eop   <= eop;
        s_mod   <= md;
        s_par   <= ^d ^ bad ^ odd;
        do begin
            @(posedge pclk);
        end while (s_ready !== 1'b1);
        s_valid <= 1'b0;
    endtask

    // two-word packet, second word may carry a parity fault
    task automatic pkt(input logic [31:0] w0, w1, input logic [1:0] md,
                       input logic bad, emode, epin);
        logic [7:0]  b;
        logic [31:0] w;
        logic        e;
        int          nb, n;
        nb = 8 - md;
        n = 0;
        exp_q = {};
        for (int i = 0; i < nb; i++) begin
            w = (i < 4) ? w0 : w1;
            b = w[31 - 8 * (i % 4) -: 8];
            e = bad && i >= 4;
            exp_q.push_back({i == 0, i == nb - 1, epin && e && i == nb - 1,
                             emode ? e : ^b ^ e ^ odd, b});
        end
        sw(w0, 1'b1, 1'b0, 2'h0, 1'b0);
        sw(w1, 1'b0, 1'b1, md, bad);
        repeat (2) @(posedge pclk);
        check(a_ppav, 1'b1);
        run <= 1'b1;
        while (u_link.q.size() < 3 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        // far side pauses mid-packet
        stall <= 1'b1;
        repeat (60) @(posedge pclk);
        stall <= 1'b0;
        while (u_link.q.size() < nb && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        run <= 1'b0;
        repeat (40) @(posedge pclk);
        check(u_link.q.size(), nb);
        foreach (exp_q[i])
            check(u_link.q[i], exp_q[i]);
        check(u_link.last_ch, 3'h3);
        check(a_ppav, 1'b0);
        u_link.q = {};
    endtask

    // ********************************************************
    // clock, watchdog, sequence
    // ********************************************************
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        repeat (30000) @(posedge pclk);
        err_count++;
        print_verdict();
    end

    initial begin
        {presetn, psel, penable, pwrite, s_valid, s_sop, s_eop} = '0;
        {s_par, run, stall, paddr, pwdata, s_data, s_mod} = '0;
        tethered = 1'b1;
        // first packet runs with odd parity, the second with even
        odd = 1'b1;
        err_count = 0;
        n_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        check(rdata, 32'h05);
        apb(1'b0, REG_STATUS, 32'h0);
        check(rdata & 32'hF00, 32'h900);
        apb(1'b0, 8'h10, 32'h0);
        check(rerr, 1'b1);
        check(rdata, 32'h0);
        apb(1'b1, REG_CTRL, 32'h39);
        apb(1'b0, REG_CTRL, 32'h0);
        check(rdata, 32'h39);
        pkt(32'h12345678, 32'h9ABCDEF0, 2'h1, 1'b1, 1'b0, 1'b0);
        apb(1'b0, REG_ERRCNT, 32'h0);
        check(rdata, 32'h1);
        apb(1'b1, REG_ERRCNT, 32'h0);
        apb(1'b1, REG_CTRL, 32'h37);
        odd = 1'b0;
        pkt(32'hA5C30F81, 32'h7E24B6D9, 2'h0, 1'b1, 1'b1, 1'b1);
        apb(1'b0, REG_ERRCNT, 32'h0);
        check(rdata, 32'h1);
        apb(1'b0, REG_PKTCNT, 32'h0);
        check(rdata, 32'h2);
        check(timed_out, 1'b0);
        tethered <= 1'b0;
        for (int n = 0; n < 5000 && timed_out !== 1'b1; n++)
            @(posedge pclk);
        repeat (2) @(posedge pclk);
        check(timed_out, 1'b1);
        check({a_err, a_wr, s_ready, a_ppav}, 4'h8);
        apb(1'b0, REG_STATUS, 32'h0);
        check(rdata & 32'h200, 32'h200);
        print_verdict();
    end
endmodule
